// *** clock_flags_pkg.sv ***
// Purpose: shared constants for the clock flag and synthesiser register block
// Assumes: classic wishbone, 32-bit data, one register per aligned word
// Notes: register indices are word numbers; byte address is index times four
package clock_flags_pkg;
   // ***************************************************************
   // bus shape
   // ***************************************************************
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int IDX_W = 6;
   localparam int IDX_LSB = 2;
   // ***************************************************************
   // register indices
   // ***************************************************************
   localparam logic [IDX_W-1:0] IDX_MULT = 6'h00;
   localparam logic [IDX_W-1:0] IDX_REFDIV = 6'h01;
   localparam logic [IDX_W-1:0] IDX_FTEST = 6'h02;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h03;
   localparam logic [IDX_W-1:0] IDX_IRQEN = 6'h04;
   localparam logic [IDX_W-1:0] IDX_SRCSEL = 6'h05;
   // ***************************************************************
   // field widths and positions
   // ***************************************************************
   localparam int MULT_W = 6;
   localparam int REFDIV_W = 4;
   localparam int RATIO_W = 8;
   localparam int DIVOUT_W = 5;
   localparam int BIT_TICK = 7;
   localparam int BIT_POR = 6;
   localparam int BIT_LV = 5;
   localparam int BIT_LOCKCHG = 4;
   localparam int BIT_LOCK = 3;
   localparam int BIT_TRACK = 2;
   localparam int BIT_SCMCHG = 1;
   localparam int BIT_SCM = 0;
   localparam int BIT_SRCSEL = 7;
   localparam logic [7:0] IRQEN_MASK = 8'h92;
   // ***************************************************************
   // reset values and constants
   // ***************************************************************
   localparam logic [MULT_W-1:0] MULT_RST = 6'h00;
   localparam logic [REFDIV_W-1:0] REFDIV_RST = 4'h0;
   localparam logic [7:0] IRQEN_RST = 8'h00;
   localparam logic [7:0] FTEST_VALUE = 8'h00;
   localparam logic [RATIO_W-1:0] MULT_GAIN = 8'h02;
   localparam logic [0:0] BUS_DIV = 1'h1;
endpackage : clock_flags_pkg

// *** w1c_flag.sv ***
// Purpose: sticky flag, set by hardware, cleared by writing one
// Assumes: set and clear are single-cycle strobes on clk_i
// Notes: KEEP=1 makes the flag survive system reset
`timescale 1ns/1ps
module w1c_flag #(
   parameter bit KEEP = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   // ***************************************************************
   // flag state
   // ***************************************************************
   // set beats clear so an event landing on a clear is never lost
   always_ff @(posedge clk_i) begin
      if (rst_i && !KEEP) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end

   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      set_i |=> flag_o)
      else $error("flag lost a set");
   a_clr_works: assert property (@(posedge clk_i) disable iff (rst_i)
      clr_i && !set_i |=> !flag_o)
      else $error("flag not cleared");
endmodule : w1c_flag

// *** tick_div.sv ***
// Purpose: divides a stream of input ticks by a programmable count plus one
// Assumes: tick_i is a one-cycle strobe on clk_i
// Notes: a change of div_i takes effect at once, compared against the running count
`timescale 1ns/1ps
module tick_div #(
   parameter int W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic [W-1:0] div_i,
   output logic tick_o
);
   logic [W-1:0] cnt_q;

   if (W < 1) begin : g_bad_width
      $error("tick_div needs W of at least one");
   end

   // ***************************************************************
   // counter
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (tick_i) begin
            if (cnt_q >= div_i) begin
               cnt_q <= '0;
               tick_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule : tick_div

// *** clock_flags.sv ***
// Purpose: synthesiser ratio registers, clock status flags and their request
// Assumes: all status inputs synchronous to clk_i; classic wishbone slave
// Notes: the analog loop stays outside; only its lock and track levels and its synth clock ticks enter
`timescale 1ns/1ps
// Function
// - synth ratio is two times multiplier plus one
// - crystal divided by reference divider plus one
// - multiplier writes ignored while synth selected
// - reference divider writes ignored while synth selected
// - accepted ratio write reinitialises lock and track
// - bus clock is selected clock halved
// - factory test register reads zero, ignores writes
// - tick flag set per period, write-one clears
// - power-on flag survives system reset, write-one clears
// - low-voltage flag, zero when detection absent
// - lock change flag set on lock toggle
// - lock status, forced low in self-clock
// - track status, forced low in self-clock
// - self-clock change flag set on status toggle
// - self-clock status shows crystal clock missing
// - tick flag with enable requests interrupt
// - lock change flag with enable requests interrupt
// - self-clock change flag with enable requests interrupt
// - interrupt enable register read and written, only bits 7, 4 and 1 kept
// - multiplier six bits, top two read zero
// - reference divider four bits, top read zero
// - source select picks crystal or synth clock
module clock_flags
   import clock_flags_pkg::*;
#(
   parameter bit LV_PRESENT = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [clock_flags_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [clock_flags_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic [clock_flags_pkg::DAT_W-1:0] wb_dat_i,
   output logic [clock_flags_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic crystal_tick_i,
   input wire logic synth_tick_i,
   input wire logic periodic_tick_i,
   input wire logic power_on_i,
   input wire logic low_voltage_i,
   input wire logic pll_locked_i,
   input wire logic pll_tracking_i,
   input wire logic selfclock_i,
   output logic irq_o,
   output logic [clock_flags_pkg::RATIO_W-1:0] synth_ratio_o,
   output logic [clock_flags_pkg::DIVOUT_W-1:0] ref_div_o,
   output logic ref_tick_o,
   output logic bus_tick_o,
   output logic pll_source_select_o
);
   import clock_flags_pkg::*;

   if (IDX_LSB + IDX_W != ADR_W) begin : g_bad_split
      $error("address split does not match bus width");
   end

   // ***************************************************************
   // bus decode
   // ***************************************************************
   logic access;
   logic wr;
   logic [IDX_W-1:0] idx;
   logic [7:0] wbyte;
   logic mult_wr;
   logic refdiv_wr;
   logic flags_wr;
   logic ratio_reinit;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = access && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
   assign wbyte = wb_dat_i[7:0];
   assign mult_wr = wr && idx == IDX_MULT && !pll_source_select_o;
   assign refdiv_wr = wr && idx == IDX_REFDIV && !pll_source_select_o;
   assign flags_wr = wr && idx == IDX_FLAGS;
   assign ratio_reinit = mult_wr || refdiv_wr;

   // ***************************************************************
   // ratio registers
   // ***************************************************************
   logic [MULT_W-1:0] mult_q;
   logic [REFDIV_W-1:0] refdiv_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mult_q <= MULT_RST;
      end else if (mult_wr) begin
         mult_q <= wbyte[MULT_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refdiv_q <= REFDIV_RST;
      end else if (refdiv_wr) begin
         refdiv_q <= wbyte[REFDIV_W-1:0];
      end
   end

   // loop target ratio and reference division handed to the analog loop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         synth_ratio_o <= MULT_GAIN;
         ref_div_o <= DIVOUT_W'(1);
      end else begin
         synth_ratio_o <= RATIO_W'(MULT_GAIN * (RATIO_W'(mult_q) + RATIO_W'(1)));
         ref_div_o <= DIVOUT_W'(refdiv_q) + DIVOUT_W'(1);
      end
   end

   // ***************************************************************
   // source select and clock dividers
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pll_source_select_o <= 1'b0;
      end else if (selfclock_i) begin
         pll_source_select_o <= 1'b0;
      end else if (wr && idx == IDX_SRCSEL) begin
         pll_source_select_o <= wbyte[BIT_SRCSEL];
      end
   end

   // comparison reference: crystal ticks divided by divider plus one
   tick_div #(.W(REFDIV_W)) u_ref_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(crystal_tick_i),
      .div_i(refdiv_q),
      .tick_o(ref_tick_o)
   );

   logic src_tick;
   assign src_tick = pll_source_select_o ? synth_tick_i : crystal_tick_i;

   // bus rate is always half the selected source
   tick_div #(.W(1)) u_bus_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(src_tick),
      .div_i(BUS_DIV),
      .tick_o(bus_tick_o)
   );

   // ***************************************************************
   // status bits
   // ***************************************************************
   logic lock_q;
   logic lock_d;
   logic track_q;
   logic scm_q;

   // a ratio write drops lock for one cycle so software sees a fresh acquisition
   assign lock_d = pll_locked_i && !selfclock_i && !ratio_reinit;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         track_q <= 1'b0;
      end else begin
         track_q <= pll_tracking_i && !selfclock_i && !ratio_reinit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scm_q <= 1'b0;
      end else begin
         scm_q <= selfclock_i;
      end
   end

   // ***************************************************************
   // sticky flags
   // ***************************************************************
   logic tick_flag;
   logic power_on_flag;
   logic low_voltage_flag;
   logic lock_chg_flag;
   logic scm_chg_flag;
   logic lv_set;

   assign lv_set = LV_PRESENT && low_voltage_i;

   w1c_flag #(.KEEP(1'b0)) u_tick_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(periodic_tick_i),
      .clr_i(flags_wr && wbyte[BIT_TICK]),
      .flag_o(tick_flag)
   );

   // por and low-voltage flags must outlive the reset they report
   w1c_flag #(.KEEP(1'b1)) u_por_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(power_on_i),
      .clr_i(flags_wr && wbyte[BIT_POR]),
      .flag_o(power_on_flag)
   );

   w1c_flag #(.KEEP(1'b1)) u_lv_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(lv_set),
      .clr_i(flags_wr && wbyte[BIT_LV]),
      .flag_o(low_voltage_flag)
   );

   w1c_flag #(.KEEP(1'b0)) u_lock_chg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(lock_d != lock_q),
      .clr_i(flags_wr && wbyte[BIT_LOCKCHG]),
      .flag_o(lock_chg_flag)
   );

   w1c_flag #(.KEEP(1'b0)) u_scm_chg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(selfclock_i != scm_q),
      .clr_i(flags_wr && wbyte[BIT_SCMCHG]),
      .flag_o(scm_chg_flag)
   );

   logic [7:0] flags_val;
   always_comb begin
      flags_val = 8'h00;
      flags_val[BIT_TICK] = tick_flag;
      flags_val[BIT_POR] = power_on_flag;
      flags_val[BIT_LV] = low_voltage_flag && LV_PRESENT;
      flags_val[BIT_LOCKCHG] = lock_chg_flag;
      flags_val[BIT_LOCK] = lock_q;
      flags_val[BIT_TRACK] = track_q;
      flags_val[BIT_SCMCHG] = scm_chg_flag;
      flags_val[BIT_SCM] = scm_q;
   end

   // ***************************************************************
   // interrupt enable and request
   // ***************************************************************
   logic [7:0] irqen_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irqen_q <= IRQEN_RST;
      end else if (wr && idx == IDX_IRQEN) begin
         irqen_q <= wbyte & IRQEN_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (tick_flag && irqen_q[BIT_TICK])
            || (lock_chg_flag && irqen_q[BIT_LOCKCHG])
            || (scm_chg_flag && irqen_q[BIT_SCMCHG]);
      end
   end

   // ***************************************************************
   // read path and acknowledge
   // ***************************************************************
   logic [7:0] rbyte;
   always_comb begin
      unique case (idx)
         IDX_MULT: rbyte = 8'(mult_q);
         IDX_REFDIV: rbyte = 8'(refdiv_q);
         IDX_FTEST: rbyte = FTEST_VALUE;
         IDX_FLAGS: rbyte = flags_val;
         IDX_IRQEN: rbyte = irqen_q;
         IDX_SRCSEL: rbyte = {pll_source_select_o, 7'h00};
         default: rbyte = 8'h00;
      endcase
   end

   // one wait state: answer is registered, unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= (access && !wb_we_i) ? DAT_W'(rbyte) : '0;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_write(logic [IDX_W-1:0] which);
      wr && idx == which;
   endsequence

   sequence s_selected_write(logic [IDX_W-1:0] which);
      s_write(which) ##0 pll_source_select_o;
   endsequence

   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      access |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle pulse");
   a_mult_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      s_selected_write(IDX_MULT) |=> $stable(mult_q))
      else $error("multiplier changed while synth selected");
   a_refdiv_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      s_selected_write(IDX_REFDIV) |=> $stable(refdiv_q))
      else $error("divider changed while synth selected");
   a_reinit_status: assert property (@(posedge clk_i) disable iff (rst_i)
      ratio_reinit |=> !lock_q && !track_q)
      else $error("lock or track kept over ratio write");
   a_ftest_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      access && !wb_we_i && idx == IDX_FTEST |=> wb_dat_o == '0)
      else $error("factory test register read nonzero");
   a_tick_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      periodic_tick_i |=> tick_flag)
      else $error("tick flag not set");
   a_lock_change: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(lock_q) |-> lock_chg_flag)
      else $error("lock change not flagged");
   a_scm_change: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(scm_q) |-> scm_chg_flag)
      else $error("self-clock change not flagged");
   a_selfclock_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      selfclock_i |=> !lock_q && !track_q)
      else $error("lock or track high in self-clock");
   a_tick_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_flag && irqen_q[BIT_TICK] |=> irq_o)
      else $error("tick interrupt not raised");
   a_mult_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      access && !wb_we_i && idx == IDX_MULT |=> wb_dat_o[7:MULT_W] == '0)
      else $error("multiplier upper bits nonzero");
   a_bus_half: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_tick_o |-> !$past(bus_tick_o))
      else $error("bus tick faster than half rate");
endmodule : clock_flags

// *** clock_flags_tb_top.sv ***
// Purpose: self-checking bench for the clock flag and synthesiser register block
// Assumes: classic wishbone single cycles, one byte per word in the low lane
// Notes: power-on and low-voltage flags are pulsed before use, they skip rst_i
`timescale 1ns/1ps
module clock_flags_tb_top;
   import clock_flags_pkg::*;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam logic [ADR_W-1:0] A_MULT = {IDX_MULT, 2'b00};
   localparam logic [ADR_W-1:0] A_DIV = {IDX_REFDIV, 2'b00};
   localparam logic [ADR_W-1:0] A_TEST = {IDX_FTEST, 2'b00};
   localparam logic [ADR_W-1:0] A_FLAGS = {IDX_FLAGS, 2'b00};
   localparam logic [ADR_W-1:0] A_IRQEN = {IDX_IRQEN, 2'b00};
   localparam logic [ADR_W-1:0] A_SRC = {IDX_SRCSEL, 2'b00};
   localparam int LIMIT = 4000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [SEL_W-1:0] sel = '0;
   logic [DAT_W-1:0] dat = '0;
   logic [4:0] ev = '0;
   logic locked = 1'b0;
   logic tracking = 1'b0;
   logic selfclk = 1'b0;
   logic [DAT_W-1:0] dat_o;
   logic ack;
   logic irq_o;
   logic [RATIO_W-1:0] ratio;
   logic [DIVOUT_W-1:0] rdiv;
   logic ref_tick;
   logic bus_tick;
   logic src_sel;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc_cnt = 0;
   int ref_cnt = 0;
   int bus_cnt = 0;
   int r0;
   int b0;

   clock_flags i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .crystal_tick_i(ev[3]), .synth_tick_i(ev[4]),
      .periodic_tick_i(ev[0]), .power_on_i(ev[1]), .low_voltage_i(ev[2]),
      .pll_locked_i(locked), .pll_tracking_i(tracking), .selfclock_i(selfclk),
      .irq_o(irq_o), .synth_ratio_o(ratio), .ref_div_o(rdiv), .ref_tick_o(ref_tick),
      .bus_tick_o(bus_tick), .pll_source_select_o(src_sel));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // non-blocking counts so the main sequence never races them at an edge
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (ref_tick === 1'b1) ref_cnt <= ref_cnt + 1;
      if (bus_tick === 1'b1) bus_cnt <= bus_cnt + 1;
      if (cyc_cnt == LIMIT) begin
         error_cnt++;
         $display("[ERR] %0t run did not finish in time", $time);
         conclude();
      end
   end
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d,
                       input logic [SEL_W-1:0] s, output logic [DAT_W-1:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {24'h000000, d};
      // no cycle count assumed: only the bench timeout ends this wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
      logic [DAT_W-1:0] q;
      xfer(1'b1, a, d, 4'h1, q);
   endtask : wr

   task automatic rd(input logic [ADR_W-1:0] a, input logic [7:0] e);
      logic [DAT_W-1:0] q;
      xfer(1'b0, a, 8'h00, 4'h1, q);
      chk(q, {24'h000000, e});
   endtask : rd

   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge clk_i);
      ev[i] <= 1'b0;
      @(posedge clk_i);
   endtask : pulse

   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
   endtask : irq_is

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [DAT_W-1:0] q;
      do_reset();
      rd(A_MULT, 8'h00);
      rd(A_DIV, 8'h00);
      rd(A_IRQEN, 8'h00);
      chk({24'h0, ratio}, 32'h2);
      chk({27'h0, rdiv}, 32'h1);
      chk({31'h0, src_sel}, 32'h0);
      // sticky reset-cause flags, including survival of a system reset
      pulse(1);
      pulse(2);
      rd(A_FLAGS, 8'h60);
      wr(A_FLAGS, 8'h00);
      do_reset();
      rd(A_FLAGS, 8'h60);
      wr(A_FLAGS, 8'h60);
      rd(A_FLAGS, 8'h00);
      // tick flag masked, then enabled, then cleared
      pulse(0);
      rd(A_FLAGS, 8'h80);
      irq_is(1'b0);
      wr(A_IRQEN, 8'h80);
      irq_is(1'b1);
      wr(A_FLAGS, 8'h7f);
      rd(A_FLAGS, 8'h80);
      wr(A_FLAGS, 8'h80);
      irq_is(1'b0);
      // lock and track levels, lock change flag
      locked <= 1'b1;
      tracking <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(A_FLAGS, 8'h1c);
      wr(A_IRQEN, 8'h10);
      irq_is(1'b1);
      wr(A_FLAGS, 8'h10);
      rd(A_FLAGS, 8'h0c);
      irq_is(1'b0);
      wr(A_MULT, 8'h05);
      rd(A_FLAGS, 8'h1c);
      wr(A_FLAGS, 8'h10);
      // self-clock entry forces lock and track low
      selfclk <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(A_FLAGS, 8'h13);
      wr(A_IRQEN, 8'h02);
      irq_is(1'b1);
      selfclk <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(A_FLAGS, 8'h1e);
      wr(A_FLAGS, 8'h12);
      rd(A_FLAGS, 8'h0c);
      irq_is(1'b0);
      // field widths, reserved and unmapped places
      wr(A_MULT, 8'hff);
      rd(A_MULT, 8'h3f);
      chk({24'h0, ratio}, 32'h80);
      wr(A_DIV, 8'hff);
      rd(A_DIV, 8'h0f);
      chk({27'h0, rdiv}, 32'h10);
      wr(A_TEST, 8'hff);
      rd(A_TEST, 8'h00);
      wr(A_IRQEN, 8'hff);
      rd(A_IRQEN, 8'h92);
      xfer(1'b1, A_IRQEN, 8'h00, 4'h0, q);
      rd(A_IRQEN, 8'h92);
      rd(8'h20, 8'h00);
      // ratio registers locked while the synth clock is selected
      wr(A_SRC, 8'h80);
      chk({31'h0, src_sel}, 32'h1);
      wr(A_MULT, 8'h01);
      rd(A_MULT, 8'h3f);
      wr(A_DIV, 8'h01);
      rd(A_DIV, 8'h0f);
      chk({24'h0, ratio}, 32'h80);
      // dividers from a clean start
      do_reset();
      wr(A_DIV, 8'h03);
      r0 = ref_cnt;
      b0 = bus_cnt;
      repeat (8) pulse(3);
      repeat (3) @(posedge clk_i);
      chk(ref_cnt - r0, 32'd2);
      chk(bus_cnt - b0, 32'd4);
      wr(A_SRC, 8'h80);
      b0 = bus_cnt;
      repeat (8) pulse(4);
      repeat (3) @(posedge clk_i);
      chk(bus_cnt - b0, 32'd4);
      conclude();
   end
endmodule : clock_flags_tb_top
